// file: wic_regs.svh
`ifndef WIC_REGS_SVH
`define WIC_REGS_SVH
`define WIC_REG_ADDR 3'h2
`define WIC_ADDR_MSB 15
`define WIC_ADDR_LSB 13
`define WIC_LOCK_BIT 12
`define WIC_UVIE_BIT 11
`define WIC_STB_BIT 9
`define WIC_E1_MSB 7
`define WIC_E1_LSB 6
`define WIC_E2_MSB 5
`define WIC_E2_LSB 4
`define WIC_RTH_BIT 2
`define WIC_SS1_BIT 1
`define WIC_SS2_BIT 0
`define WIC_FIELD_RST 1'b0
`define WIC_EDGE_RST 2'h0
`define WIC_CLK_KHZ 200000
`define WIC_SHORT_MS 16
`define WIC_LONG_MS 64
`define WIC_BIAS_ON_US 100
`endif

// file: wic_pkg.sv
package wic_pkg;
    typedef enum logic [1:0] {
        WIC_EDGE_OFF = 2'b00,
        WIC_EDGE_RISE = 2'b01,
        WIC_EDGE_FALL = 2'b10,
        WIC_EDGE_BOTH = 2'b11
    } wic_edge_t;
    typedef enum logic [1:0] {
        WIC_MODE_STANDBY = 2'b00,
        WIC_MODE_SLEEP = 2'b01,
        WIC_MODE_NORMAL = 2'b10,
        WIC_MODE_NORMAL_ALT = 2'b11
    } wic_mode_t;
endpackage : wic_pkg

// file: wic_ctrl.sv
`timescale 1ns/1ps
`include "wic_regs.svh"
module wic_ctrl #(
    parameter int CNT_W = 24,
    parameter int SHORT_CYC = `WIC_SHORT_MS * `WIC_CLK_KHZ,
    parameter int LONG_CYC = `WIC_LONG_MS * `WIC_CLK_KHZ,
    parameter int BIAS_ON_CYC = (`WIC_BIAS_ON_US * `WIC_CLK_KHZ) / 1000
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET_N,
    input wire logic i_WR_EN,
    input wire logic [2:0] i_ADDR,
    input wire logic [15:0] i_WDATA,
    output logic [15:0] o_RDATA,
    output logic o_ADDR_HIT,
    input wire logic [1:0] i_CHIP_MODE_CODE,
    input wire logic i_UV_WARN,
    input wire logic i_SLEEP_REQ,
    input wire logic [1:0] i_WAKE_PINS,
    output logic o_UV_IRQ_REQ,
    output logic o_LIN_ACTIVE,
    output logic o_LIN_LOWPOWER,
    output logic o_LIN_WAKE_DET_EN,
    output logic o_LIN_WAKE_IRQ_ALLOW,
    output logic o_LIN_WAKE_FLAG_CLR,
    output logic [1:0] o_WAKE_IRQ_REQ,
    output logic o_WAKE_BIAS_OUTPUT,
    output logic o_RESET_LEVEL_SEL,
    output logic o_SYS_RESET_REQ,
    output logic o_SLEEP_GRANT
);
    // ------------------------------------------------------------
    // register fields
    // ------------------------------------------------------------
    logic lock_reg, uvie_reg, stb_reg, rth_reg, bias_sel_reg;
    logic [1:0] edge1_reg, edge2_reg, ssync_reg;
    wire wr_hit = i_WR_EN && (i_ADDR == `WIC_REG_ADDR);
    wire wr_ok = wr_hit && !lock_reg;
    // bias period select lives in another register; here it is held at its reset value
    wire normal_mode = i_CHIP_MODE_CODE[1];
    wire no_wake_src = !stb_reg && (edge1_reg == `WIC_EDGE_RST) && (edge2_reg == `WIC_EDGE_RST);

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            lock_reg <= `WIC_FIELD_RST;
            uvie_reg <= `WIC_FIELD_RST;
            stb_reg <= `WIC_FIELD_RST;
            rth_reg <= `WIC_FIELD_RST;
            edge1_reg <= `WIC_EDGE_RST;
            edge2_reg <= `WIC_EDGE_RST;
            ssync_reg <= `WIC_EDGE_RST;
        end else begin
            // lock stays writable so a locked register can be reopened
            if (wr_hit) begin
                lock_reg <= i_WDATA[`WIC_LOCK_BIT];
            end
            if (wr_ok) begin
                uvie_reg <= i_WDATA[`WIC_UVIE_BIT];
                stb_reg <= i_WDATA[`WIC_STB_BIT];
                edge1_reg <= i_WDATA[`WIC_E1_MSB:`WIC_E1_LSB];
                edge2_reg <= i_WDATA[`WIC_E2_MSB:`WIC_E2_LSB];
                rth_reg <= i_WDATA[`WIC_RTH_BIT];
                ssync_reg <= {i_WDATA[`WIC_SS1_BIT], i_WDATA[`WIC_SS2_BIT]};
            end
        end
    end

    // ------------------------------------------------------------
    // read path and plain control outputs
    // ------------------------------------------------------------
    wire [15:0] rd_word = {`WIC_REG_ADDR, lock_reg, uvie_reg, 1'b0, stb_reg, 1'b0,
                           edge1_reg, edge2_reg, 1'b0, rth_reg, ssync_reg};
    assign o_ADDR_HIT = (i_ADDR == `WIC_REG_ADDR);
    assign o_RDATA = o_ADDR_HIT ? rd_word : 16'h0000;
    assign o_RESET_LEVEL_SEL = rth_reg;
    assign o_LIN_ACTIVE = !stb_reg && normal_mode;
    assign o_LIN_WAKE_FLAG_CLR = !stb_reg && normal_mode;
    assign o_LIN_LOWPOWER = stb_reg;
    assign o_LIN_WAKE_DET_EN = stb_reg;
    assign o_LIN_WAKE_IRQ_ALLOW = stb_reg;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] meta_reg, sync_reg;
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            meta_reg <= 3'h0;
            sync_reg <= 3'h0;
        end else begin
            meta_reg <= {i_UV_WARN, i_WAKE_PINS};
            sync_reg <= meta_reg;
        end
    end

    // ------------------------------------------------------------
    // bias period timer
    // ------------------------------------------------------------
    // the bias period select bit belongs to another register and cannot be written from here,
    // so it stays at its reset value: only the short interval is live until a port brings it in,
    // and the long branch is kept so that hookup is a one-line change
    logic [CNT_W-1:0] cnt_reg;
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            bias_sel_reg <= `WIC_FIELD_RST;
        end else begin
            bias_sel_reg <= bias_sel_reg;
        end
    end
    wire [CNT_W-1:0] period_m1 = bias_sel_reg ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);
    wire tick = (cnt_reg == period_m1);
    wire any_sync = |ssync_reg;
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= (tick || !any_sync) ? '0 : cnt_reg + CNT_W'(1);
        end
    end
    // bias is raised just before the sample point so the pin has settled when it is taken
    assign o_WAKE_BIAS_OUTPUT = any_sync && (cnt_reg >= period_m1 - CNT_W'(BIAS_ON_CYC));

    // ------------------------------------------------------------
    // wake sampling and edge detection
    // ------------------------------------------------------------
    logic [1:0] smp_reg, prev_reg, wirq_reg;
    // index 0 is the first wake input, whose sync bit sits above the second one's in the word
    wire [1:0] sync_en = {ssync_reg[0], ssync_reg[1]};
    logic [1:0] edge_f [2];
    assign edge_f[0] = edge1_reg;
    assign edge_f[1] = edge2_reg;
    // samplers reset low, so a pin that idles high gives one rising edge after reset
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_wake
            wire take = !sync_en[gi] || tick;
            wire rise = smp_reg[gi] && !prev_reg[gi];
            wire fall = !smp_reg[gi] && prev_reg[gi];
            wire hit = (rise && edge_f[gi][0]) || (fall && edge_f[gi][1]);
            always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
                if (!I_RESET_N) begin
                    smp_reg[gi] <= 1'b0;
                    prev_reg[gi] <= 1'b0;
                    wirq_reg[gi] <= 1'b0;
                end else begin
                    if (take) begin
                        smp_reg[gi] <= sync_reg[gi];
                    end
                    prev_reg[gi] <= smp_reg[gi];
                    wirq_reg[gi] <= hit;
                end
            end
        end
    endgenerate
    assign o_WAKE_IRQ_REQ = wirq_reg;

    // ------------------------------------------------------------
    // undervoltage request and sleep check
    // ------------------------------------------------------------
    logic uvirq_reg, sysrst_reg, grant_reg;
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            uvirq_reg <= 1'b0;
            sysrst_reg <= 1'b0;
            grant_reg <= 1'b0;
        end else begin
            uvirq_reg <= uvie_reg && sync_reg[2];
            sysrst_reg <= i_SLEEP_REQ && no_wake_src;
            grant_reg <= i_SLEEP_REQ && !no_wake_src;
        end
    end
    assign o_UV_IRQ_REQ = uvirq_reg;
    assign o_SYS_RESET_REQ = sysrst_reg;
    assign o_SLEEP_GRANT = grant_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESET_N);
    sequence locked_write_s;
        lock_reg && wr_hit;
    endsequence
    lock_hold_a: assert property (locked_write_s |=>
        $stable({uvie_reg, stb_reg, edge1_reg, edge2_reg, rth_reg, ssync_reg}))
        else $error("locked register took a write");
    uv_gate_a: assert property (o_UV_IRQ_REQ |-> $past(uvie_reg) && $past(sync_reg[2]))
        else $error("undervoltage request without enable");
    lin_normal_a: assert property ((!stb_reg && normal_mode) |-> o_LIN_ACTIVE && o_LIN_WAKE_FLAG_CLR)
        else $error("lin not active in normal mode");
    lin_off_a: assert property ((!stb_reg && !normal_mode) |->
        !o_LIN_ACTIVE && !o_LIN_WAKE_DET_EN && !o_LIN_WAKE_IRQ_ALLOW)
        else $error("lin not off in standby or sleep");
    lin_low_a: assert property (stb_reg |->
        o_LIN_LOWPOWER && o_LIN_WAKE_DET_EN && o_LIN_WAKE_IRQ_ALLOW && !o_LIN_ACTIVE)
        else $error("lin not in low power");
    first_local_wake_input_edge_a: assert property (o_WAKE_IRQ_REQ[0] |-> $past(edge1_reg) != wic_pkg::WIC_EDGE_OFF)
        else $error("wake 1 request while disabled");
    second_local_wake_input_edge_a: assert property (o_WAKE_IRQ_REQ[1] |-> $past(edge2_reg) != wic_pkg::WIC_EDGE_OFF)
        else $error("wake 2 request while disabled");
    reset_level_a: assert property (wr_ok |=> o_RESET_LEVEL_SEL == $past(i_WDATA[`WIC_RTH_BIT]))
        else $error("reset level not taken from write");
    sync_hold_a: assert property ((sync_en[0] && !tick) |=> $stable(smp_reg[0]))
        else $error("synchronised sample moved off tick");
    read_code_a: assert property (o_ADDR_HIT |-> o_RDATA[15:13] == 3'h2 && o_RDATA[10] == 1'b0
        && o_RDATA[8] == 1'b0 && o_RDATA[3] == 1'b0)
        else $error("read word code or reserved bits wrong");
    sleep_reset_a: assert property ((i_SLEEP_REQ && no_wake_src) |=> o_SYS_RESET_REQ && !o_SLEEP_GRANT)
        else $error("sleep without wake source not turned into reset");
    sleep_grant_a: assert property ((i_SLEEP_REQ && !no_wake_src) |=> o_SLEEP_GRANT && !o_SYS_RESET_REQ)
        else $error("sleep with wake source not granted");
    uv_block_a: assert property (!uvie_reg |=> !o_UV_IRQ_REQ)
        else $error("undervoltage request while disabled");
    sync_hold2_a: assert property ((sync_en[1] && !tick) |=> $stable(smp_reg[1]))
        else $error("second synchronised sample moved off tick");
    bias_low_a: assert property (!any_sync |-> !o_WAKE_BIAS_OUTPUT)
        else $error("bias raised with no synchronised input");
    wake_off_a: assert property ((edge1_reg == wic_pkg::WIC_EDGE_OFF && edge2_reg == wic_pkg::WIC_EDGE_OFF) |=>
        o_WAKE_IRQ_REQ == 2'h0)
        else $error("wake request with both edge fields off");
    // the timer must count one step per cycle between ticks, else the interval drifts
    sequence bias_tick_s;
        any_sync && tick;
    endsequence
    bias_step_a: assert property ((any_sync && !tick) |=> !any_sync || cnt_reg == $past(cnt_reg) + CNT_W'(1))
        else $error("bias timer skipped a count");
    bias_short_a: assert property (bias_tick_s |-> bias_sel_reg || cnt_reg == CNT_W'(SHORT_CYC - 1))
        else $error("short sampling interval has wrong length");
endmodule : wic_ctrl

// file: wic_host.sv
`timescale 1ns/1ps
module wic_host (
    input wire logic i_clk,
    input wire logic [15:0] i_rdata,
    output logic o_wr_en,
    output logic [2:0] o_addr,
    output logic [15:0] o_wdata
);
    initial begin
        o_wr_en = 1'b0;
        o_addr = 3'h0;
        o_wdata = 16'h0;
    end
    // stale data is inverted so a late write never looks like a repeat
    task automatic write_reg(input logic [15:0] w);
        @(posedge i_clk);
        #1;
        o_wr_en = 1'b1;
        o_addr = 3'h2;
        o_wdata = w;
        @(posedge i_clk);
        #1;
        o_wr_en = 1'b0;
        o_wdata = ~w;
    endtask : write_reg
    task automatic read_reg(input logic [2:0] a, output logic [15:0] r);
        @(posedge i_clk);
        #1;
        o_addr = a;
        @(posedge i_clk);
        r = i_rdata;
        #1;
    endtask : read_reg
endmodule : wic_host

// file: wic_ctrl_bench.sv
`timescale 1ns/1ps
module wic_ctrl_bench;
    logic clk, rst_n, wr_en, sleep_req, uv_warn, hit, uv_irq, bias, rth, sys_rst, grant;
    logic a, b, c, d, e;
    logic [2:0] addr;
    logic [15:0] wdata, rdata, cur, r, w;
    logic [1:0] mode, wake, irq;
    logic [7:0] up, dn;
    int num_errors = 0;
    int num_checks = 0;
    integer seed = 25;
    int n, hi;
    wic_ctrl #(.SHORT_CYC(40), .LONG_CYC(100), .BIAS_ON_CYC(4)) i_dut (.I_CORE_CLK(clk), .I_RESET_N(rst_n),
        .i_WR_EN(wr_en), .i_ADDR(addr), .i_WDATA(wdata), .o_RDATA(rdata), .o_ADDR_HIT(hit),
        .i_CHIP_MODE_CODE(mode), .i_UV_WARN(uv_warn), .i_SLEEP_REQ(sleep_req), .i_WAKE_PINS(wake),
        .o_UV_IRQ_REQ(uv_irq), .o_LIN_ACTIVE(a), .o_LIN_LOWPOWER(c), .o_LIN_WAKE_DET_EN(d),
        .o_LIN_WAKE_IRQ_ALLOW(e), .o_LIN_WAKE_FLAG_CLR(b), .o_WAKE_IRQ_REQ(irq), .o_WAKE_BIAS_OUTPUT(bias),
        .o_RESET_LEVEL_SEL(rth), .o_SYS_RESET_REQ(sys_rst), .o_SLEEP_GRANT(grant));
    wic_host i_host (.i_clk(clk), .i_rdata(rdata), .o_wr_en(wr_en), .o_addr(addr), .o_wdata(wdata));
    // ----------------------------------------
    // expectations and reporting
    // ----------------------------------------
    function automatic logic [15:0] next_word(input logic [15:0] cw, input logic [15:0] dw);
        return cw[12] ? ((cw & 16'h0af7) | (dw & 16'h1000)) : (dw & 16'h1af7);
    endfunction : next_word
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic count_pulses(output logic [7:0] cnt);
        cnt = 8'h0;
        repeat (8) begin
            @(posedge clk);
            #1;
            cnt[3:0] += irq[0];
            cnt[7:4] += irq[1];
        end
    endtask : count_pulses
    task automatic sleep_try(input logic [1:0] exp);
        sleep_req = 1'b1;
        @(posedge clk);
        #1;
        sleep_req = 1'b0;
        check("sleep outcome", {14'h0, sys_rst, grant}, {14'h0, exp});
    endtask : sleep_try
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #200000;
        num_errors++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        sleep_req = 1'b0;
        uv_warn = 1'b0;
        mode = 2'h2;
        wake = 2'h0;
        cur = 16'h0;
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        i_host.read_reg(3'h5, r);
        check("unmapped", {r[15:1], hit}, 16'h0);
        i_host.read_reg(3'h2, r);
        check("reset word", {r[15:1], hit}, 16'h4001);
        for (n = 0; n < 24; n++) begin
            w = 16'($random(seed));
            mode = 2'($random(seed));
            wake = 2'($random(seed));
            uv_warn = 1'($random(seed));
            i_host.write_reg(w);
            cur = next_word(cur, w);
            i_host.read_reg(3'h2, r);
            check("readback", r, cur | 16'h4000);
            check("reset level", {15'h0, rth}, {15'h0, cur[2]});
            check("lin", {11'h0, a, b, c, d, e}, {11'h0, {2{~cur[9] & mode[1]}}, {3{cur[9]}}});
            check("uv level", {15'h0, uv_irq}, {15'h0, cur[11] & uv_warn});
        end
        wake = 2'h0;
        uv_warn = 1'b0;
        i_host.write_reg(16'h0);
        i_host.write_reg(16'h0);
        for (n = 0; n < 2; n++) begin
            i_host.write_reg(n[0] ? 16'h0800 : 16'h0);
            uv_warn = 1'b1;
            repeat (4) @(posedge clk);
            #1;
            check("uv request", {15'h0, uv_irq}, {15'h0, n[0]});
            uv_warn = 1'b0;
            repeat (4) @(posedge clk);
            #1;
            check("uv idle", {15'h0, uv_irq}, 16'h0);
        end
        for (n = 0; n < 16; n++) begin
            i_host.write_reg({8'h0, n[3:0], 4'h0});
            wake = 2'h3;
            count_pulses(up);
            wake = 2'h0;
            count_pulses(dn);
            check("wake edges", {up, dn}, {3'h0, n[0], 3'h0, n[2], 3'h0, n[1], 3'h0, n[3]});
            sleep_try((n == 0) ? 2'b10 : 2'b01);
        end
        i_host.write_reg(16'h0200);
        sleep_try(2'b01);
        for (n = 0; n < 2; n++) begin
            i_host.write_reg(n[0] ? 16'h0003 : 16'h0);
            hi = 0;
            repeat (80) begin
                @(posedge clk);
                #1;
                hi += bias;
            end
            check("bias cycles", {15'h0, hi >= 8 && hi <= 10}, {15'h0, n[0]});
        end
        complete_run();
    end
endmodule : wic_ctrl_bench
